/* File: prcg_pkg.sv */
// Constants, field positions and carrier types for the peripheral reset and clock gate block
package prcg_pkg;

    // Bus geometry
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int LANES   = 4;
    localparam int LANE_W  = 8;

    typedef logic [DATA_W-1:0] prcg_word_type;
    typedef logic [LANES-1:0]  prcg_be_type;
    typedef logic [ADDR_W-1:0] prcg_addr_type;

    // Register byte offsets
    localparam prcg_addr_type FAST_BUS_PERIPHERAL_RESET_OFFSET          = 8'h24;
    localparam prcg_addr_type SYSTEM_BUS_PERIPHERAL_CLOCK_ENABLE_OFFSET = 8'h30;
    localparam int            WORD_ALIGN_BITS                           = 2;

    // Reset values and implemented-bit masks
    localparam prcg_word_type RESET_REG_RESET_VALUE = 32'h0000_0000;
    localparam prcg_word_type RESET_REG_MASK        = 32'h0007_5933;
    localparam prcg_word_type CLOCK_REG_RESET_VALUE = 32'h0010_0000;
    localparam prcg_word_type CLOCK_REG_MASK        = 32'h7E74_11FF;
    localparam prcg_word_type ZERO_WORD             = 32'h0000_0000;

    // Peripheral reset register fields
    localparam int RST_TIMER_1_BIT       = 0;
    localparam int RST_TIMER_8_BIT       = 1;
    localparam int RST_SERIAL_1_BIT      = 4;
    localparam int RST_SERIAL_6_BIT      = 5;
    localparam int RST_CONVERTER_BIT     = 8;
    localparam int RST_CARD_BIT          = 11;
    localparam int RST_SPI_PORT_1_BIT    = 12;
    localparam int RST_SYS_CONFIG_BIT    = 14;
    localparam int RST_TIMER_9_BIT       = 16;
    localparam int RST_TIMER_10_BIT      = 17;
    localparam int RST_TIMER_11_BIT      = 18;

    // Number of converter instances sharing one reset bit
    localparam int NUM_CONVERTERS        = 3;

    // Clock enable register fields
    localparam int CLK_IO_PORT_LSB       = 0;
    localparam int NUM_IO_PORTS          = 9;
    localparam int CLK_CHECKSUM_BIT      = 12;
    localparam int CLK_BACKUP_SRAM_BIT   = 18;
    localparam int CLK_DATA_RAM_BIT      = 20;
    localparam int CLK_FIRST_DMA_BIT     = 21;
    localparam int CLK_SECOND_DMA_BIT    = 22;
    localparam int CLK_ETH_CORE_BIT      = 25;
    localparam int CLK_ETH_TX_BIT        = 26;
    localparam int CLK_ETH_RX_BIT        = 27;
    localparam int CLK_ETH_PTP_BIT       = 28;
    localparam int CLK_OTG_BIT           = 29;
    localparam int CLK_OTG_PHY_BIT       = 30;

    // Register access request
    typedef struct packed {
        prcg_addr_type addr;
        logic          write;
        logic          read;
        prcg_be_type   byte_en;
        prcg_word_type wdata;
    } prcg_bus_req_type;

    // Reset lines, high holds the peripheral in reset
    typedef struct packed {
        logic timer_1;
        logic timer_8;
        logic serial_1;
        logic serial_6;
        logic card_interface;
        logic spi_port_1;
        logic sys_config;
        logic timer_9;
        logic timer_10;
        logic timer_11;
    } prcg_reset_lines_type;

    // Clock gate enables, high lets the clock run
    typedef struct packed {
        logic [NUM_IO_PORTS-1:0] io_port;
        logic checksum_unit_clock_gate;
        logic backup_sram_clock_gate;
        logic data_ram_clock_gate;
        logic first_dma_clock_gate;
        logic second_dma_clock_gate;
        logic ethernet_core_clock_gate;
        logic ethernet_transmit_clock_gate;
        logic ethernet_receive_clock_gate;
        logic ethernet_timestamp_clock_gate;
        logic high_speed_otg_clock_gate;
        logic otg_phy_interface_clock_gate;
    } prcg_clock_gates_type;

    // Expand byte enables to a bit mask
    function automatic prcg_word_type prcg_lane_mask(input prcg_be_type be);
        prcg_word_type m;
        m = ZERO_WORD;
        for (int i = 0; i < LANES; i++) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{be[i]}};
        end
        return m;
    endfunction

endpackage

/* File: prcg_reg_word.sv */
// One 32-bit software register with byte-lane writes and an implemented-bit mask
`timescale 1ns/1ps
`default_nettype none
module prcg_reg_word
    import prcg_pkg::*;
#(
    parameter prcg_word_type RESET_VALUE = 32'h0000_0000,
    parameter prcg_word_type WRITABLE    = 32'h0000_0000
) (
    // Clock and reset
    input  wire logic          sys_clk_in,
    input  wire logic          srst_in,
    // Write port
    input  wire logic          wr_en_in,
    input  wire prcg_be_type   byte_en_in,
    input  wire prcg_word_type wdata_in,
    // Stored value
    output var  prcg_word_type q_out
);

    prcg_word_type next_q;
    prcg_word_type write_mask;

    always_comb begin
        // Reserved positions never take a write, so they stay zero
        write_mask = prcg_lane_mask(byte_en_in) & WRITABLE;
        next_q     = q_out;
        if (wr_en_in) begin
            next_q = (q_out & ~write_mask) | (wdata_in & write_mask);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            q_out <= RESET_VALUE & WRITABLE;
        end else begin
            q_out <= next_q;
        end
    end

endmodule // prcg_reg_word
`default_nettype wire

/* File: prcg_top.sv */
// Peripheral reset register and system bus clock enable register with their output lines
//
// Function
// - 32-bit reset register, zero at reset; set bits hold peripherals in reset.
// - Word, half-word and byte reads and writes, all without wait cycles.
// - Software sets and clears each reset bit; writing zero releases.
// - Converter reset bit drives the reset of every converter instance together.
// - 32-bit clock enable register, reset leaves only data RAM clock on.
// - Bit 20 gates the clock-management data RAM clock.
// - Bit 18 gates the battery-backed SRAM interface clock.
// - Ethernet gates: 25 core, 26 transmit, 27 receive, 28 timestamp.
// - Bit 29 gates high-speed OTG, bit 30 its PHY interface clock.
`timescale 1ns/1ps
`default_nettype none
module prcg_top
    import prcg_pkg::*;
(
    // Clock and reset
    input  wire logic                      sys_clk_in,
    input  wire logic                      srst_in,
    // Register access
    input  wire prcg_bus_req_type          bus_req_in,
    output logic                           bus_ready_out,
    output var  prcg_word_type             bus_rdata_out,
    output var  logic                      bus_rvalid_out,
    output var  logic                      bus_error_out,
    // Peripheral reset lines
    output logic                           converter_interface_reset,
    output logic [NUM_CONVERTERS-1:0]      converter_reset_out,
    output prcg_reset_lines_type           periph_reset_out,
    // Peripheral clock gates
    output prcg_clock_gates_type           clock_gate_out,
    // Status
    output logic                           any_reset_active_out
);

    // Word address match, low bits are carried by the byte enables
    function automatic logic reg_hit(input prcg_addr_type addr, input prcg_addr_type offset);
        return addr[ADDR_W-1:WORD_ALIGN_BITS] == offset[ADDR_W-1:WORD_ALIGN_BITS];
    endfunction

    logic          hit_reset;
    logic          hit_clock;
    logic          wr_reset;
    logic          wr_clock;
    prcg_word_type fast_bus_peripheral_reset;
    prcg_word_type system_bus_peripheral_clock_enable;
    prcg_word_type next_rdata;
    logic          next_rvalid;
    logic          next_error;

    // Decode
    always_comb begin
        hit_reset = reg_hit(bus_req_in.addr, FAST_BUS_PERIPHERAL_RESET_OFFSET);
        hit_clock = reg_hit(bus_req_in.addr, SYSTEM_BUS_PERIPHERAL_CLOCK_ENABLE_OFFSET);
        wr_reset  = bus_req_in.write & hit_reset;
        wr_clock  = bus_req_in.write & hit_clock;
    end

    // Every access is taken in the cycle it is presented
    assign bus_ready_out = 1'b1;

    prcg_reg_word #(
        .RESET_VALUE (RESET_REG_RESET_VALUE),
        .WRITABLE    (RESET_REG_MASK)
    ) u_reset_reg (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .wr_en_in   (wr_reset),
        .byte_en_in (bus_req_in.byte_en),
        .wdata_in   (bus_req_in.wdata),
        .q_out      (fast_bus_peripheral_reset)
    );

    prcg_reg_word #(
        .RESET_VALUE (CLOCK_REG_RESET_VALUE),
        .WRITABLE    (CLOCK_REG_MASK)
    ) u_clock_reg (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .wr_en_in   (wr_clock),
        .byte_en_in (bus_req_in.byte_en),
        .wdata_in   (bus_req_in.wdata),
        .q_out      (system_bus_peripheral_clock_enable)
    );

    // Read data and error, one cycle after the request
    always_comb begin
        next_rdata  = ZERO_WORD;
        next_rvalid = bus_req_in.read;
        next_error  = (bus_req_in.read | bus_req_in.write) & ~(hit_reset | hit_clock);
        if (bus_req_in.read && hit_reset) begin
            next_rdata = fast_bus_peripheral_reset & RESET_REG_MASK;
        end else if (bus_req_in.read && hit_clock) begin
            next_rdata = system_bus_peripheral_clock_enable & CLOCK_REG_MASK;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            bus_rdata_out  <= ZERO_WORD;
            bus_rvalid_out <= 1'b0;
            bus_error_out  <= 1'b0;
        end else begin
            bus_rdata_out  <= next_rdata;
            bus_rvalid_out <= next_rvalid;
            bus_error_out  <= next_error;
        end
    end

    // Reset lines follow the stored bits directly, so release needs a zero write
    always_comb begin
        periph_reset_out.timer_1        = fast_bus_peripheral_reset[RST_TIMER_1_BIT];
        periph_reset_out.timer_8        = fast_bus_peripheral_reset[RST_TIMER_8_BIT];
        periph_reset_out.serial_1       = fast_bus_peripheral_reset[RST_SERIAL_1_BIT];
        periph_reset_out.serial_6       = fast_bus_peripheral_reset[RST_SERIAL_6_BIT];
        periph_reset_out.card_interface = fast_bus_peripheral_reset[RST_CARD_BIT];
        periph_reset_out.spi_port_1     = fast_bus_peripheral_reset[RST_SPI_PORT_1_BIT];
        periph_reset_out.sys_config     = fast_bus_peripheral_reset[RST_SYS_CONFIG_BIT];
        periph_reset_out.timer_9        = fast_bus_peripheral_reset[RST_TIMER_9_BIT];
        periph_reset_out.timer_10       = fast_bus_peripheral_reset[RST_TIMER_10_BIT];
        periph_reset_out.timer_11       = fast_bus_peripheral_reset[RST_TIMER_11_BIT];
        converter_interface_reset       = fast_bus_peripheral_reset[RST_CONVERTER_BIT];
        any_reset_active_out            = |(fast_bus_peripheral_reset & RESET_REG_MASK);
    end

    // One stored bit fans out to all converters, they cannot be reset one by one
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CONVERTERS; gc++) begin : g_conv_reset
            assign converter_reset_out[gc] = converter_interface_reset;
        end
    endgenerate

    // Level enables for the clock gating cells outside, one process owns the whole struct
    always_comb begin
        clock_gate_out.io_port =
            system_bus_peripheral_clock_enable[CLK_IO_PORT_LSB +: NUM_IO_PORTS];
        clock_gate_out.checksum_unit_clock_gate =
            system_bus_peripheral_clock_enable[CLK_CHECKSUM_BIT];
        clock_gate_out.backup_sram_clock_gate =
            system_bus_peripheral_clock_enable[CLK_BACKUP_SRAM_BIT];
        clock_gate_out.data_ram_clock_gate =
            system_bus_peripheral_clock_enable[CLK_DATA_RAM_BIT];
        clock_gate_out.first_dma_clock_gate =
            system_bus_peripheral_clock_enable[CLK_FIRST_DMA_BIT];
        clock_gate_out.second_dma_clock_gate =
            system_bus_peripheral_clock_enable[CLK_SECOND_DMA_BIT];
        clock_gate_out.ethernet_core_clock_gate =
            system_bus_peripheral_clock_enable[CLK_ETH_CORE_BIT];
        clock_gate_out.ethernet_transmit_clock_gate =
            system_bus_peripheral_clock_enable[CLK_ETH_TX_BIT];
        clock_gate_out.ethernet_receive_clock_gate =
            system_bus_peripheral_clock_enable[CLK_ETH_RX_BIT];
        clock_gate_out.ethernet_timestamp_clock_gate =
            system_bus_peripheral_clock_enable[CLK_ETH_PTP_BIT];
        clock_gate_out.high_speed_otg_clock_gate =
            system_bus_peripheral_clock_enable[CLK_OTG_BIT];
        clock_gate_out.otg_phy_interface_clock_gate =
            system_bus_peripheral_clock_enable[CLK_OTG_PHY_BIT];
    end

endmodule // prcg_top
`default_nettype wire

/* File: prcg_chk.sv */
// Bound checker for the peripheral reset and clock gate block
`timescale 1ns/1ps
`default_nettype none
module prcg_chk
    import prcg_pkg::*;
(
    // Clock and reset
    input  wire logic                      sys_clk_in,
    input  wire logic                      srst_in,
    // Register access
    input  wire prcg_bus_req_type          bus_req_in,
    input  wire logic                      bus_ready_out,
    input  wire prcg_word_type             bus_rdata_out,
    input  wire logic                      bus_rvalid_out,
    input  wire logic                      bus_error_out,
    // Reset lines and clock gates
    input  wire logic                      converter_interface_reset,
    input  wire logic [NUM_CONVERTERS-1:0] converter_reset_out,
    input  wire prcg_reset_lines_type      periph_reset_out,
    input  wire prcg_clock_gates_type      clock_gate_out,
    input  wire logic                      any_reset_active_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    logic hit_rst;
    logic hit_clk;
    assign hit_rst = bus_req_in.addr[7:2] == 6'h09;
    assign hit_clk = bus_req_in.addr[7:2] == 6'h0C;
    sequence s_rd_req;
        bus_req_in.read;
    endsequence
    // Pulse lasts one cycle unless another read follows
    sequence s_rd_ans;
        bus_rvalid_out ##1 (bus_rvalid_out == $past(bus_req_in.read));
    endsequence
    a_ready_always: assert property (bus_ready_out)
        else $error("bus ready dropped");
    a_read_answer: assert property (s_rd_req |=> s_rd_ans)
        else $error("read answer pulse wrong");
    a_rdata_idle: assert property (!bus_req_in.read |=> bus_rdata_out == 32'h0000_0000)
        else $error("read data not zero when idle");
    a_unmapped_err: assert property ((bus_req_in.read || bus_req_in.write) && !hit_rst
        && !hit_clk |=> bus_error_out)
        else $error("no error pulse on unmapped access");
    a_reset_vals: assert property ($fell(srst_in) |-> clock_gate_out.data_ram_clock_gate
        && !any_reset_active_out && !bus_rvalid_out)
        else $error("outputs not at reset values");
    a_conv_all: assert property (converter_reset_out == {3{converter_interface_reset}})
        else $error("converter resets differ");
    a_conv_write: assert property (bus_req_in.write && hit_rst && bus_req_in.byte_en[1]
        |=> converter_interface_reset == $past(bus_req_in.wdata[8]))
        else $error("converter reset bit not written");
    a_dram_write: assert property (bus_req_in.write && hit_clk && bus_req_in.byte_en[2]
        |=> clock_gate_out.data_ram_clock_gate == $past(bus_req_in.wdata[20]))
        else $error("data ram gate not written");
    a_hold_nowrite: assert property (!bus_req_in.write
        |=> $stable(clock_gate_out) && $stable(periph_reset_out))
        else $error("outputs changed without a write");
endmodule // prcg_chk
bind prcg_top prcg_chk prcg_chk_i (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .bus_req_in(bus_req_in), .bus_ready_out(bus_ready_out), .bus_rdata_out(bus_rdata_out),
    .bus_rvalid_out(bus_rvalid_out), .bus_error_out(bus_error_out),
    .converter_interface_reset(converter_interface_reset),
    .converter_reset_out(converter_reset_out), .periph_reset_out(periph_reset_out),
    .clock_gate_out(clock_gate_out), .any_reset_active_out(any_reset_active_out));
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench for the peripheral reset and clock gate block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import prcg_pkg::*;
;
    // Implemented bits kept apart from the design's own masks
    localparam prcg_word_type RST_BITS = 32'h0007_5933;
    localparam prcg_word_type CLK_BITS = 32'h7E74_11FF;
    logic                      sys_clk_in = 1'b0;
    logic                      srst_in    = 1'b1;
    prcg_bus_req_type          bus_req_in = '0;
    logic                      bus_ready_out;
    prcg_word_type             bus_rdata_out;
    logic                      bus_rvalid_out;
    logic                      bus_error_out;
    logic                      converter_interface_reset;
    logic [NUM_CONVERTERS-1:0] converter_reset_out;
    prcg_reset_lines_type      periph_reset_out;
    prcg_clock_gates_type      clock_gate_out;
    logic                      any_reset_active_out;
    prcg_word_type             m_rst;
    prcg_word_type             m_clk;
    prcg_word_type             lm;
    prcg_word_type             exp_g;
    prcg_word_type             exp_q[$];
    logic                      exp_err;
    logic                      hit_r;
    logic                      hit_c;
    int                        errors      = 0;
    int                        checks_done = 0;
    int                        cycles      = 0;
    prcg_addr_type             addr_tab[7] = '{8'h24, 8'h30, 8'h28, 8'h00, 8'hFC, 8'h27, 8'h33};

    prcg_top prcg_top_i (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .bus_req_in(bus_req_in),
        .bus_ready_out(bus_ready_out), .bus_rdata_out(bus_rdata_out),
        .bus_rvalid_out(bus_rvalid_out), .bus_error_out(bus_error_out),
        .converter_interface_reset(converter_interface_reset),
        .converter_reset_out(converter_reset_out), .periph_reset_out(periph_reset_out),
        .clock_gate_out(clock_gate_out), .any_reset_active_out(any_reset_active_out));

    always #50 sys_clk_in = ~sys_clk_in;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string n, input prcg_word_type e, input prcg_word_type g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic op(input logic w, input logic r, input prcg_addr_type a,
                      input prcg_be_type b, input prcg_word_type d);
        @(negedge sys_clk_in);
        bus_req_in = '{addr: a, write: w, read: r, byte_en: b, wdata: d};
    endtask

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles >= 3000) begin
            errors++;
            end_sim();
        end
    end

    // Model notes the expected answer at the edge that takes the request
    always @(posedge sys_clk_in) begin
        for (int i = 0; i < 32; i++) lm[i] = bus_req_in.byte_en[i/8];
        hit_r = bus_req_in.addr[7:2] == 6'h09;
        hit_c = bus_req_in.addr[7:2] == 6'h0C;
        if (srst_in) begin
            m_rst = 32'h0000_0000;
            m_clk = 32'h0010_0000;
            exp_err = 1'b0;
            exp_q.delete();
        end else begin
            if (bus_req_in.read) exp_q.push_back(hit_r ? m_rst : (hit_c ? m_clk : '0));
            exp_err = (bus_req_in.read || bus_req_in.write) && !hit_r && !hit_c;
            if (bus_req_in.write && hit_r) m_rst = (m_rst & ~lm) | (bus_req_in.wdata & lm & RST_BITS);
            if (bus_req_in.write && hit_c) m_clk = (m_clk & ~lm) | (bus_req_in.wdata & lm & CLK_BITS);
        end
    end

    assign exp_g = 32'({m_clk[8:0], m_clk[12], m_clk[18], m_clk[20], m_clk[21], m_clk[22],
                        m_clk[25], m_clk[26], m_clk[27], m_clk[28], m_clk[29], m_clk[30]});

    always @(negedge sys_clk_in) begin
        chk("ready", 32'h0000_0001, 32'(bus_ready_out));
        chk("error", 32'(exp_err), 32'(bus_error_out));
        chk("rvalid", 32'(exp_q.size() != 0), 32'(bus_rvalid_out));
        if (exp_q.size() != 0) chk("rdata", exp_q.pop_front(), bus_rdata_out);
        chk("resets", 32'({m_rst[0], m_rst[1], m_rst[4], m_rst[5], m_rst[11], m_rst[12],
            m_rst[14], m_rst[16], m_rst[17], m_rst[18]}), 32'(periph_reset_out));
        chk("converter", 32'({4{m_rst[8]}}),
            32'({converter_interface_reset, converter_reset_out}));
        chk("gates", exp_g, 32'(clock_gate_out));
        chk("any_reset", 32'(|m_rst), 32'(any_reset_active_out));
    end

    initial begin
        void'($urandom(56490));
        repeat (4) @(negedge sys_clk_in);
        srst_in = 1'b0;
        op(1'b0, 1'b1, 8'h24, 4'hF, '0);
        op(1'b0, 1'b1, 8'h30, 4'hF, '0);
        $display("test reset_values done");
        op(1'b1, 1'b0, 8'h24, 4'hF, 32'hFFFF_FFFF);
        op(1'b1, 1'b0, 8'h30, 4'hF, 32'hFFFF_FFFF);
        op(1'b0, 1'b1, 8'h24, 4'hF, '0);
        op(1'b0, 1'b1, 8'h30, 4'hF, '0);
        op(1'b1, 1'b1, 8'h26, 4'h2, '0);
        op(1'b1, 1'b1, 8'h32, 4'hC, '0);
        op(1'b1, 1'b1, 8'h28, 4'hF, 32'hFFFF_FFFF);
        op(1'b0, 1'b1, 8'h30, 4'hF, '0);
        // Let the read above be taken before reset swallows the bus
        op(1'b0, 1'b0, '0, '0, '0);
        srst_in = 1'b1;
        op(1'b0, 1'b0, '0, '0, '0);
        srst_in = 1'b0;
        op(1'b0, 1'b1, 8'h30, 4'hF, '0);
        $display("test directed done");
        repeat (400) op(1'($urandom), 1'($urandom), addr_tab[$urandom_range(6)],
                        4'($urandom), $urandom);
        op(1'b0, 1'b0, '0, '0, '0);
        repeat (2) @(negedge sys_clk_in);
        $display("test random done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
